// *** rtl/cbg_glue_top.sv ***
// core boot, event and timer privilege glue with register port
`timescale 1ns/100ps
`default_nettype none
module cbg_glue_top (
    input  wire logic                    ref_clk_i,
    input  wire logic                    rst_b_i,
    input  wire logic [7:0]              reg_addr_i,
    input  wire logic [31:0]             reg_wdata_i,
    input  wire logic                    reg_wr_i,
    input  wire logic                    reg_rd_i,
    input  wire logic                    reg_priv_i,
    output logic      [31:0]             reg_rdata_o,
    input  wire logic                    core_event_receive_in_i,
    output logic                         core_event_send_out_o,
    input  wire logic                    timer_a_privileged_write_only_i,
    input  wire logic                    timer_b_privileged_write_only_i,
    output cbg_pkg::cbg_flash_req_t      flash_target_port_o,
    input  wire logic [31:0]             flash_rdata_i,
    input  wire logic                    flash_rvalid_i,
    output logic      [31:0]             boot_pc_o,
    output logic                         core_sleeping_o
);
    // straps come from pins: two flops before use
    logic [1:0] strap_meta_reg;
    logic [1:0] strap_sync_reg;
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            strap_meta_reg <= 2'h0;
            strap_sync_reg <= 2'h0;
        end else begin
            strap_meta_reg <= {timer_b_privileged_write_only_i,
                               timer_a_privileged_write_only_i};
            strap_sync_reg <= strap_meta_reg;
        end
    end

    // register decode
    logic wr_ctrl;
    logic wr_status;
    logic wr_event;
    logic [1:0] wr_timer;
    assign wr_ctrl     = reg_wr_i & (reg_addr_i == cbg_pkg::OFS_CTRL);
    assign wr_status   = reg_wr_i & (reg_addr_i == cbg_pkg::OFS_STATUS);
    assign wr_event    = reg_wr_i & (reg_addr_i == cbg_pkg::OFS_EVENT);
    assign wr_timer[0] = reg_wr_i & (reg_addr_i == cbg_pkg::OFS_TIMER_A);
    assign wr_timer[1] = reg_wr_i & (reg_addr_i == cbg_pkg::OFS_TIMER_B);

    logic [1:0][31:0] timer_value;
    logic [1:0]       timer_refused;
    cbg_timer_guard cbg_timer_guard_inst (
        .ref_clk_i   (ref_clk_i),
        .rst_b_i     (rst_b_i),
        .wr_sel_i    (wr_timer),
        .wdata_i     (reg_wdata_i),
        .priv_i      (reg_priv_i),
        .priv_only_i (strap_sync_reg),
        .value_o     (timer_value),
        .refused_o   (timer_refused)
    );

    // core state
    cbg_pkg::cbg_state_t     state_reg;
    cbg_pkg::cbg_state_t     state_next;
    cbg_pkg::cbg_flash_req_t flash_reg;
    cbg_pkg::cbg_flash_req_t flash_next;
    logic [31:0] sp_reg;
    logic [31:0] sp_next;
    logic [31:0] vec_reg;
    logic [31:0] vec_next;
    logic        size512_reg;
    logic        size512_next;
    logic        latch_reg;
    logic        latch_next;
    logic        send_reg;
    logic        send_next;
    logic [1:0]  refuse_reg;
    logic [1:0]  refuse_next;
    logic        vecout_reg;
    logic        vecout_next;
    logic [31:0] region;
    logic        vec_reset;

    assign vec_reset = wr_ctrl & reg_wdata_i[cbg_pkg::CTRL_VECRST_BIT];

    always_comb begin
        state_next   = state_reg;
        flash_next   = flash_reg;
        sp_next      = sp_reg;
        vec_next     = vec_reg;
        size512_next = size512_reg;
        latch_next   = latch_reg | core_event_receive_in_i;
        send_next    = 1'b0;
        vecout_next  = vecout_reg;
        region       = size512_reg ? cbg_pkg::FLASH_SIZE_512K
                                   : cbg_pkg::FLASH_SIZE_256K;
        // hardware set wins over software clear
        refuse_next  = refuse_reg;
        if (wr_status) begin
            refuse_next = refuse_reg &
                ~reg_wdata_i[cbg_pkg::ST_REFUSE_LO +: 2];
        end
        refuse_next = refuse_next | timer_refused;
        if (wr_ctrl) begin
            size512_next = reg_wdata_i[cbg_pkg::CTRL_SIZE_BIT];
        end
        case (state_reg)
            cbg_pkg::CBG_HOLD: begin
                // boot fetches go straight to flash: zero is hard-mapped
                flash_next.req  = 1'b1;
                flash_next.addr = cbg_pkg::BOOT_SP_ADDR;
                state_next      = cbg_pkg::CBG_GET_SP;
            end
            cbg_pkg::CBG_GET_SP: begin
                if (flash_rvalid_i) begin
                    sp_next         = flash_rdata_i;
                    flash_next.addr = cbg_pkg::BOOT_VEC_ADDR;
                    state_next      = cbg_pkg::CBG_GET_VEC;
                end
            end
            cbg_pkg::CBG_GET_VEC: begin
                if (flash_rvalid_i) begin
                    vec_next       = flash_rdata_i;
                    vecout_next    = flash_rdata_i >= region;
                    flash_next.req = 1'b0;
                    state_next     = cbg_pkg::CBG_RUN;
                end
            end
            cbg_pkg::CBG_RUN: begin
                if (wr_event) begin
                    send_next = reg_wdata_i[cbg_pkg::EVT_SEND_BIT];
                    if (reg_wdata_i[cbg_pkg::EVT_WAIT_BIT]) begin
                        // a pending event cancels the wait at once
                        if (latch_next) begin
                            latch_next = 1'b0;
                        end else begin
                            state_next = cbg_pkg::CBG_SLEEP;
                        end
                    end
                end
            end
            cbg_pkg::CBG_SLEEP: begin
                if (core_event_receive_in_i) begin
                    latch_next = 1'b0;
                    state_next = cbg_pkg::CBG_RUN;
                end
            end
            default: begin
                state_next = cbg_pkg::CBG_HOLD;
            end
        endcase
        // vector reset restarts the core only, not the glue
        if (vec_reset) begin
            state_next     = cbg_pkg::CBG_HOLD;
            flash_next.req = 1'b0;
            sp_next        = '0;
            vec_next       = '0;
            latch_next     = 1'b0;
            send_next      = 1'b0;
            vecout_next    = 1'b0;
        end
    end

    // read data: one cycle later, zero for unmapped addresses
    logic [31:0] rdata_next;
    logic [31:0] status_word;
    always_comb begin
        status_word = '0;
        status_word[cbg_pkg::ST_RUN_BIT]     = state_reg[3] | state_reg[4];
        status_word[cbg_pkg::ST_SLEEP_BIT]   = state_reg[4];
        status_word[cbg_pkg::ST_STRAP_LO+:2] = strap_sync_reg;
        status_word[cbg_pkg::ST_REFUSE_LO+:2] = refuse_reg;
        status_word[cbg_pkg::ST_LATCH_BIT]   = latch_reg;
        status_word[cbg_pkg::ST_VECOUT_BIT]  = vecout_reg;
        rdata_next = '0;
        if (reg_rd_i) begin
            case (reg_addr_i)
                cbg_pkg::OFS_CTRL: begin
                    rdata_next[cbg_pkg::CTRL_SIZE_BIT] = size512_reg;
                end
                cbg_pkg::OFS_STATUS: begin
                    rdata_next = status_word;
                end
                cbg_pkg::OFS_BOOT_SP: begin
                    rdata_next = sp_reg;
                end
                cbg_pkg::OFS_BOOT_VEC: begin
                    rdata_next = vec_reg;
                end
                cbg_pkg::OFS_TIMER_A: begin
                    rdata_next = timer_value[0];
                end
                cbg_pkg::OFS_TIMER_B: begin
                    rdata_next = timer_value[1];
                end
                default: begin
                    rdata_next = '0;
                end
            endcase
        end
    end

    // single clock, no gating anywhere in this block
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_reg   <= cbg_pkg::CBG_HOLD;
            flash_reg   <= '0;
            sp_reg      <= '0;
            vec_reg     <= '0;
            size512_reg <= cbg_pkg::CTRL_SIZE_RST;
            latch_reg   <= 1'b0;
            send_reg    <= 1'b0;
            refuse_reg  <= 2'h0;
            vecout_reg  <= 1'b0;
            reg_rdata_o <= '0;
        end else begin
            state_reg   <= state_next;
            flash_reg   <= flash_next;
            sp_reg      <= sp_next;
            vec_reg     <= vec_next;
            size512_reg <= size512_next;
            latch_reg   <= latch_next;
            send_reg    <= send_next;
            refuse_reg  <= refuse_next;
            vecout_reg  <= vecout_next;
            reg_rdata_o <= rdata_next;
        end
    end

    assign flash_target_port_o   = flash_reg;
    assign core_event_send_out_o = send_reg;
    assign boot_pc_o             = vec_reg;
    assign core_sleeping_o       = state_reg[4];
endmodule : cbg_glue_top
`default_nettype wire

// *** rtl/cbg_pkg.sv ***
// package: register map, field positions, boot constants and shared types
package cbg_pkg;
    localparam int          REG_AW          = 8;
    localparam int          DATA_W          = 32;
    localparam int          NUM_TIMERS      = 2;
    // register offsets
    localparam logic [7:0]  OFS_CTRL        = 8'h00;
    localparam logic [7:0]  OFS_STATUS      = 8'h04;
    localparam logic [7:0]  OFS_EVENT       = 8'h08;
    localparam logic [7:0]  OFS_BOOT_SP     = 8'h0c;
    localparam logic [7:0]  OFS_BOOT_VEC    = 8'h10;
    localparam logic [7:0]  OFS_TIMER_A     = 8'h14;
    localparam logic [7:0]  OFS_TIMER_B     = 8'h18;
    // control fields
    localparam int          CTRL_VECRST_BIT = 0;
    localparam int          CTRL_SIZE_BIT   = 1;
    localparam logic        CTRL_SIZE_RST   = 1'b1;
    // event fields
    localparam int          EVT_SEND_BIT    = 0;
    localparam int          EVT_WAIT_BIT    = 1;
    // status fields
    localparam int          ST_RUN_BIT      = 0;
    localparam int          ST_SLEEP_BIT    = 1;
    localparam int          ST_STRAP_LO     = 2;
    localparam int          ST_REFUSE_LO    = 4;
    localparam int          ST_LATCH_BIT    = 6;
    localparam int          ST_VECOUT_BIT   = 7;
    // boot fetch addresses, flash region sizes and timer reset value
    localparam logic [31:0] BOOT_SP_ADDR    = 32'h0000_0000;
    localparam logic [31:0] BOOT_VEC_ADDR   = 32'h0000_0004;
    localparam logic [31:0] FLASH_SIZE_256K = 32'h0004_0000;
    localparam logic [31:0] FLASH_SIZE_512K = 32'h0008_0000;
    localparam logic [31:0] TIMER_RST_VAL   = 32'h0000_0000;

    typedef enum logic [5:0] {
        CBG_HOLD    = 6'b000001,
        CBG_GET_SP  = 6'b000010,
        CBG_GET_VEC = 6'b000100,
        CBG_RUN     = 6'b001000,
        CBG_SLEEP   = 6'b010000,
        CBG_SPARE   = 6'b100000
    } cbg_state_t;

    typedef struct packed {
        logic        req;
        logic [31:0] addr;
    } cbg_flash_req_t;
endpackage : cbg_pkg

// *** rtl/cbg_timer_guard.sv ***
// timer register write gate with per-timer privilege straps
`timescale 1ns/100ps
`default_nettype none
module cbg_timer_guard (
    input  wire logic                    ref_clk_i,
    input  wire logic                    rst_b_i,
    input  wire logic [1:0]              wr_sel_i,
    input  wire logic [31:0]             wdata_i,
    input  wire logic                    priv_i,
    input  wire logic [1:0]              priv_only_i,
    output logic      [1:0][31:0]        value_o,
    output logic      [1:0]              refused_o
);
    genvar g;
    generate
        for (g = 0; g < cbg_pkg::NUM_TIMERS; g++) begin : g_tmr
            logic [31:0] value_reg;
            logic [31:0] value_next;
            logic        refused_reg;
            logic        refused_next;
            logic        allowed;
            // reads are never gated, only writes
            always_comb begin
                allowed      = priv_i | ~priv_only_i[g];
                value_next   = value_reg;
                refused_next = 1'b0;
                if (wr_sel_i[g]) begin
                    if (allowed) begin
                        value_next = wdata_i;
                    end else begin
                        refused_next = 1'b1;
                    end
                end
            end
            always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
                if (!rst_b_i) begin
                    value_reg   <= cbg_pkg::TIMER_RST_VAL;
                    refused_reg <= 1'b0;
                end else begin
                    value_reg   <= value_next;
                    refused_reg <= refused_next;
                end
            end
            assign value_o[g]   = value_reg;
            assign refused_o[g] = refused_reg;
        end
    endgenerate
endmodule : cbg_timer_guard
`default_nettype wire

// *** sim/cbg_flash_model.sv ***
// flash target model answering boot fetches after a set delay
`timescale 1ns/100ps
`default_nettype none
module cbg_flash_model (
    input  wire logic                    ref_clk_i,
    input  wire logic                    rst_b_i,
    input  wire cbg_pkg::cbg_flash_req_t req_i,
    input  wire logic [3:0]              delay_i,
    input  wire logic [31:0]             sp_word_i,
    input  wire logic [31:0]             vec_word_i,
    output logic      [31:0]             rdata_o,
    output logic                         rvalid_o
);
    logic [3:0] cnt_reg;
    // cache, bank control and irq 14/15 hookup not modelled
    // same clock as the glue, no crossing here
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cnt_reg  <= 4'h0;
            rvalid_o <= 1'b0;
            rdata_o  <= 32'h0;
        end else begin
            rvalid_o <= 1'b0;
            // idle data toggles so a stale word cannot pass
            rdata_o  <= ~rdata_o;
            cnt_reg  <= 4'h0;
            if (req_i.req && !rvalid_o) begin
                if (cnt_reg >= delay_i) begin
                    rvalid_o <= 1'b1;
                    rdata_o  <= (req_i.addr == cbg_pkg::BOOT_SP_ADDR) ?
                                sp_word_i : vec_word_i;
                end else begin
                    cnt_reg <= cnt_reg + 4'h1;
                end
            end
        end
    end
endmodule : cbg_flash_model
`default_nettype wire

// *** sim/cbg_glue_assertions.sv ***
// port checks for the boot, event and vector reset glue
`timescale 1ns/100ps
`default_nettype none
module cbg_glue_assertions (
    input  wire logic                    ref_clk_i,
    input  wire logic                    rst_b_i,
    input  wire logic [7:0]              reg_addr_i,
    input  wire logic [31:0]             reg_wdata_i,
    input  wire logic                    reg_wr_i,
    input  wire logic                    core_event_receive_in_i,
    input  wire logic                    core_event_send_out_o,
    input  wire cbg_pkg::cbg_flash_req_t flash_target_port_o,
    input  wire logic [31:0]             flash_rdata_i,
    input  wire logic                    flash_rvalid_i,
    input  wire logic [31:0]             boot_pc_o,
    input  wire logic                    core_sleeping_o
);
    logic        req;
    logic [31:0] fa;
    logic        wr_evt;
    assign req    = flash_target_port_o.req;
    assign fa     = flash_target_port_o.addr;
    assign wr_evt = reg_wr_i && (reg_addr_i == cbg_pkg::OFS_EVENT);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_b_i);
    boot_start_a: assert property ($rose(rst_b_i) |-> ##[0:1]
        (req && fa == cbg_pkg::BOOT_SP_ADDR)) else $error("no boot fetch");
    sp_to_vec_a: assert property (req && fa == cbg_pkg::BOOT_SP_ADDR &&
        flash_rvalid_i |=> req && fa == cbg_pkg::BOOT_VEC_ADDR)
        else $error("vector fetch missing");
    vec_done_a: assert property (req && fa == cbg_pkg::BOOT_VEC_ADDR &&
        flash_rvalid_i |=> !req && boot_pc_o == $past(flash_rdata_i))
        else $error("boot vector not taken");
    fetch_hold_a: assert property (req && !flash_rvalid_i |=>
        req && $stable(fa)) else $error("fetch dropped early");
    zero_to_flash_a: assert property (req |->
        fa == cbg_pkg::BOOT_SP_ADDR || fa == cbg_pkg::BOOT_VEC_ADDR)
        else $error("fetch address off boot pair");
    send_once_a: assert property (core_event_send_out_o |=>
        !core_event_send_out_o) else $error("send pulse too long");
    send_cause_a: assert property (core_event_send_out_o |->
        $past(wr_evt && reg_wdata_i[cbg_pkg::EVT_SEND_BIT]))
        else $error("send pulse without cause");
    sleep_cause_a: assert property ($rose(core_sleeping_o) |->
        $past(wr_evt && reg_wdata_i[cbg_pkg::EVT_WAIT_BIT]))
        else $error("sleep without wait request");
    wake_up_a: assert property (core_sleeping_o && core_event_receive_in_i
        |=> !core_sleeping_o) else $error("event did not wake core");
    vec_restart_a: assert property (reg_wr_i &&
        reg_addr_i == cbg_pkg::OFS_CTRL &&
        reg_wdata_i[cbg_pkg::CTRL_VECRST_BIT] |-> ##[1:2] !req ##1
        (req && fa == cbg_pkg::BOOT_SP_ADDR)) else $error("no reboot");
endmodule : cbg_glue_assertions
bind cbg_glue_top cbg_glue_assertions cbg_glue_assertions_inst (
    .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .core_event_receive_in_i(core_event_receive_in_i),
    .core_event_send_out_o(core_event_send_out_o),
    .flash_target_port_o(flash_target_port_o),
    .flash_rdata_i(flash_rdata_i), .flash_rvalid_i(flash_rvalid_i),
    .boot_pc_o(boot_pc_o), .core_sleeping_o(core_sleeping_o));
`default_nettype wire

// *** sim/tb.sv ***
// self-checking bench for the boot, event and timer glue
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic                    clk = 1'b0;
    logic                    rst_b = 1'b0;
    logic [7:0]              addr = 8'h00;
    logic [31:0]             wdata = 32'h0;
    logic                    wr = 1'b0;
    logic                    rd = 1'b0;
    logic                    priv = 1'b0;
    logic                    rx = 1'b0;
    logic                    strap_a = 1'b1;
    logic                    strap_b = 1'b0;
    logic [3:0]              delay = 4'h5;
    logic [31:0]             sp_w = 32'h2000_1000;
    logic [31:0]             vec_w = 32'h0000_0101;
    logic [31:0]             rdata, f_rdata, boot_pc;
    logic                    send, sleeping, f_rvalid;
    cbg_pkg::cbg_flash_req_t f_req;
    int                      n_errors = 0;
    int                      compares = 0;
    int                      n_send = 0;
    int                      cycles = 0;
    // strap a set as an rtos-minded integrator would, strap b raised once and lowered again
    cbg_glue_top cbg_glue_top_inst (.ref_clk_i(clk), .rst_b_i(rst_b),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_priv_i(priv), .reg_rdata_o(rdata), .core_event_receive_in_i(rx),
        .core_event_send_out_o(send),
        .timer_a_privileged_write_only_i(strap_a),
        .timer_b_privileged_write_only_i(strap_b),
        .flash_target_port_o(f_req), .flash_rdata_i(f_rdata),
        .flash_rvalid_i(f_rvalid), .boot_pc_o(boot_pc),
        .core_sleeping_o(sleeping));
    cbg_flash_model cbg_flash_model_inst (.ref_clk_i(clk), .rst_b_i(rst_b),
        .req_i(f_req), .delay_i(delay), .sp_word_i(sp_w),
        .vec_word_i(vec_w), .rdata_o(f_rdata), .rvalid_o(f_rvalid));
    always #2.5 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (send === 1'b1) n_send++;
        if (cycles == 4000) begin
            n_errors++;
            finish_test();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d,
                          input logic p);
        @(posedge clk);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d;
        priv  <= p;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        rd   <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 check(rdata, exp);
    endtask : rd_chk
    // rx stands for the or of all other cores' send pulses
    task automatic pulse_rx();
        @(posedge clk);
        rx <= 1'b1;
        @(posedge clk);
        rx <= 1'b0;
    endtask : pulse_rx
    task automatic wait_boot();
        for (int i = 0; i < 100; i++) begin
            @(posedge clk);
            if (i > 3 && f_req.req === 1'b0) break;
        end
        #1;
    endtask : wait_boot
    task automatic finish_test();
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : finish_test
    initial begin
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        wait_boot();
        check(boot_pc, vec_w);
        rd_chk(cbg_pkg::OFS_BOOT_SP, sp_w);
        rd_chk(cbg_pkg::OFS_STATUS, 32'h0000_0005);
        rd_chk(cbg_pkg::OFS_CTRL, 32'h0000_0002);
        $display("boot test done");
        wr_reg(cbg_pkg::OFS_TIMER_A, 32'hdead_beef, 1'b0);
        wr_reg(cbg_pkg::OFS_TIMER_B, 32'h1234_5678, 1'b0);
        rd_chk(cbg_pkg::OFS_TIMER_A, cbg_pkg::TIMER_RST_VAL);
        rd_chk(cbg_pkg::OFS_TIMER_B, 32'h1234_5678);
        rd_chk(cbg_pkg::OFS_STATUS, 32'h0000_0015);
        wr_reg(cbg_pkg::OFS_TIMER_A, 32'ha5a5_0001, 1'b1);
        wr_reg(cbg_pkg::OFS_STATUS, 32'h0000_0010, 1'b1);
        rd_chk(cbg_pkg::OFS_TIMER_A, 32'ha5a5_0001);
        rd_chk(cbg_pkg::OFS_STATUS, 32'h0000_0005);
        // strap b raised: two sync flops before the guard sees it
        @(posedge clk);
        strap_b <= 1'b1;
        repeat (2) @(posedge clk);
        wr_reg(cbg_pkg::OFS_TIMER_B, 32'h0bad_0bad, 1'b0);
        rd_chk(cbg_pkg::OFS_TIMER_B, 32'h1234_5678);
        rd_chk(cbg_pkg::OFS_STATUS, 32'h0000_002d);
        strap_b <= 1'b0;
        wr_reg(cbg_pkg::OFS_STATUS, 32'h0000_0020, 1'b0);
        wr_reg(8'h40, 32'hffff_ffff, 1'b1);
        rd_chk(8'h40, 32'h0000_0000);
        $display("timer test done");
        n_send = 0;
        wr_reg(cbg_pkg::OFS_EVENT, 32'h0000_0001, 1'b0);
        repeat (3) @(posedge clk);
        check(32'(n_send), 32'h0000_0001);
        wr_reg(cbg_pkg::OFS_EVENT, 32'h0000_0002, 1'b0);
        #1 check(sleeping, 1'b1);
        pulse_rx();
        #1 check(sleeping, 1'b0);
        pulse_rx();
        rd_chk(cbg_pkg::OFS_STATUS, 32'h0000_0045);
        wr_reg(cbg_pkg::OFS_EVENT, 32'h0000_0002, 1'b0);
        repeat (2) @(posedge clk);
        #1 check(sleeping, 1'b0);
        $display("event test done");
        // prompt flash this time, new vector to tell the boots apart
        delay = 4'h0;
        vec_w = 32'h0000_0201;
        wr_reg(cbg_pkg::OFS_CTRL, 32'h0000_0003, 1'b1);
        wait_boot();
        check(boot_pc, 32'h0000_0201);
        rd_chk(cbg_pkg::OFS_TIMER_B, 32'h1234_5678);
        rd_chk(cbg_pkg::OFS_CTRL, 32'h0000_0002);
        wr_reg(cbg_pkg::OFS_CTRL, 32'h0000_0000, 1'b1);
        rd_chk(cbg_pkg::OFS_CTRL, 32'h0000_0000);
        $display("vector reset test done");
        @(posedge clk);
        rst_b <= 1'b0;
        #1 check(boot_pc, 32'h0000_0000);
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        wait_boot();
        check(boot_pc, 32'h0000_0201);
        rd_chk(cbg_pkg::OFS_TIMER_B, cbg_pkg::TIMER_RST_VAL);
        $display("reset test done");
        finish_test();
    end
endmodule : tb
`default_nettype wire
